/* hdl/tmr_pkg.sv */
// Purpose: constants for the eight-bit timer with shared prescaler
// Assumes: registers reached over a plain address/strobe port
// Notes: offsets are word indices on the local port
package tmr_pkg;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;
	// register offsets
	localparam logic [3:0] OFF_COUNT = 4'h0;
	localparam logic [3:0] OFF_OPTION = 4'h1;
	localparam logic [3:0] OFF_INTCTL = 4'h2;
	localparam logic [3:0] OFF_STATUS = 4'h3;
	// option register fields
	localparam int unsigned OPT_PS_LSB = 0;
	localparam int unsigned OPT_PS_W = 3;
	localparam int unsigned OPT_ASSIGN = 3;
	localparam int unsigned OPT_EDGE = 4;
	localparam int unsigned OPT_SOURCE = 5;
	localparam logic [7:0] OPTION_RESET = 8'hFF;
	// interrupt control fields
	localparam int unsigned INT_FLAG = 2;
	localparam int unsigned INT_ENABLE = 5;
	localparam logic [7:0] INTCTL_RESET = 8'h00;
	localparam logic [7:0] INTCTL_MASK = 8'h24;
	// status register fields
	localparam int unsigned ST_INHIBIT = 0;
	localparam int unsigned ST_SLEEP = 1;
	localparam int unsigned ST_ASSIGNED = 2;
	// cycles of suppressed counting after a count write
	localparam logic [1:0] WRITE_HOLD_CYCLES = 2'h2;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] COUNT_MAX = 8'hFF;
endpackage

/* hdl/tmr_edge_sync.sv */
// Purpose: brings the external count pin into core_clk and finds edges
// Assumes: pin is asynchronous to core_clk
// Notes: stage one is read by stage two only
`timescale 1ns/10ps
module tmr_edge_sync (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic pin_in,
	input wire logic fall_sel,
	output logic edge_pulse
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} sync_s;
	sync_s q, d;

	always_comb begin
		d = q;
		d.s1 = pin_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			q <= '0;
		end else if (clk_en) begin
			q <= d;
		end
	end

	// rising when select low, falling when high
	assign edge_pulse = fall_sel ? (q.s3 & ~q.s2) : (~q.s3 & q.s2);
endmodule // tmr_edge_sync

/* hdl/tmr_prescaler.sv */
// Purpose: eight-bit power-of-two divider
// Assumes: input pulses are single cycles of core_clk
// Notes: contents are never visible on the register port
`timescale 1ns/10ps
module tmr_prescaler #(
	parameter int unsigned WIDTH = 8
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic clear,
	input wire logic tick_in,
	input wire logic [2:0] ratio_sel,
	output logic tick_out
);
	typedef struct packed {
		logic [WIDTH-1:0] cnt;
	} div_s;
	div_s q, d;
	logic [WIDTH-1:0] mask;
	logic [WIDTH-1:0] nxt;

	// ratio 2^(sel+1): output when low sel+1 bits all ones
	always_comb begin
		mask = (WIDTH'(2) << ratio_sel) - WIDTH'(1);
		nxt = q.cnt + WIDTH'(1);
		tick_out = tick_in & ((q.cnt & mask) == mask);
		d = q;
		if (clear) begin
			d.cnt = '0;
		end else if (tick_in) begin
			d.cnt = nxt;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			q <= '0;
		end else if (clk_en) begin
			q <= d;
		end
	end
endmodule // tmr_prescaler

/* hdl/eight_bit_timer.sv */
// Purpose: eight-bit timer/counter with shared prescaler
// Assumes: core_clk is the instruction-cycle clock
// Notes: watchdog logic lives elsewhere; it only sees wdt_tick
//
// Functional notes
// - Source select low counts every instruction cycle.
// - A count write suppresses counting for the next two cycles.
// - Source select high counts edges on the external pin.
// - Edge select low picks rising edges, high picks falling.
// - The prescaler serves this counter or the watchdog, never both.
// - Assign bit clear gives the prescaler to the counter, set to watchdog.
// - Software can neither read nor write the prescaler contents.
// - The prescaler is an eight-bit divider with a software ratio.
// - Ratios 1:2 through 1:256 in powers of two are offered.
// - The count wraps from its maximum to zero as the interrupt event.
// - Each wrap sets the wrap flag; a clear enable bit masks the irq.
// - The timer is halted during sleep.
`timescale 1ns/10ps
module eight_bit_timer (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic external_count_pin,
	input wire logic sleep_mode,
	input wire logic wdt_timeout_in,
	output logic wdt_tick,
	output logic wrap_irq
);
	//////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [7:0] count;
		logic [7:0] option;
		logic wrap_flag;
		logic wrap_irq_enable;
		logic [1:0] hold;
		logic [7:0] rdata;
		logic sleep_s1;
		logic sleep_s2;
	} tmr_s;
	tmr_s q, d;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
		hit = (a == o);
	endfunction

	logic count_source_select;
	logic count_edge_select_bit;
	logic divider_assign_bit;
	logic ext_edge;
	logic src_tick;
	logic pre_in;
	logic pre_out;
	logic pre_clear;
	logic inc;
	logic wr_count;
	logic halted;

	assign count_source_select = q.option[tmr_pkg::OPT_SOURCE];
	assign count_edge_select_bit = q.option[tmr_pkg::OPT_EDGE];
	assign divider_assign_bit = q.option[tmr_pkg::OPT_ASSIGN];
	assign wr_count = reg_wr & hit(reg_addr, tmr_pkg::OFF_COUNT);
	// sleep comes from another power domain; synchronise it
	assign halted = q.sleep_s2;

	//////////////////////////////////////////////////////////////////////
	tmr_edge_sync u_sync (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.pin_in(external_count_pin),
		.fall_sel(count_edge_select_bit),
		.edge_pulse(ext_edge)
	);

	always_comb begin
		if (halted) begin
			src_tick = 1'b0;
		end else if (count_source_select) begin
			src_tick = ext_edge;
		end else begin
			src_tick = 1'b1;
		end
	end

	// one divider, steered by the assign bit only
	assign pre_in = divider_assign_bit ? wdt_timeout_in : src_tick;
	assign pre_clear = wr_count & ~divider_assign_bit;

	tmr_prescaler #(
		.WIDTH(8)
	) u_pre (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.clear(pre_clear),
		.tick_in(pre_in),
		.ratio_sel(q.option[tmr_pkg::OPT_PS_LSB +: tmr_pkg::OPT_PS_W]),
		.tick_out(pre_out)
	);

	// watchdog sees divided ticks only when assigned there
	assign wdt_tick = divider_assign_bit ? pre_out : wdt_timeout_in;

	// write-hold blocks even a pending prescaler output
	assign inc = (divider_assign_bit ? src_tick : pre_out)
		& (q.hold == 2'h0);

	//////////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		d.sleep_s1 = sleep_mode;
		d.sleep_s2 = q.sleep_s1;
		if (q.hold != 2'h0) begin
			d.hold = q.hold - 2'h1;
		end
		if (inc) begin
			d.count = q.count + 8'h01;
			if (q.count == tmr_pkg::COUNT_MAX) begin
				d.count = tmr_pkg::COUNT_RESET;
			end
		end
		if (reg_wr) begin
			if (hit(reg_addr, tmr_pkg::OFF_COUNT)) begin
				d.count = reg_wdata;
				d.hold = tmr_pkg::WRITE_HOLD_CYCLES;
			end
			if (hit(reg_addr, tmr_pkg::OFF_OPTION)) begin
				d.option = reg_wdata;
			end
			if (hit(reg_addr, tmr_pkg::OFF_INTCTL)) begin
				d.wrap_flag = reg_wdata[tmr_pkg::INT_FLAG];
				d.wrap_irq_enable = reg_wdata[tmr_pkg::INT_ENABLE];
			end
		end
		// a wrap in the clearing cycle still sets the flag
		if (inc && q.count == tmr_pkg::COUNT_MAX) begin
			d.wrap_flag = 1'b1;
		end
		d.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				tmr_pkg::OFF_COUNT: d.rdata = q.count;
				tmr_pkg::OFF_OPTION: d.rdata = q.option;
				tmr_pkg::OFF_INTCTL: begin
					d.rdata[tmr_pkg::INT_FLAG] = q.wrap_flag;
					d.rdata[tmr_pkg::INT_ENABLE] = q.wrap_irq_enable;
				end
				tmr_pkg::OFF_STATUS: begin
					d.rdata[tmr_pkg::ST_INHIBIT] = (q.hold != 2'h0);
					d.rdata[tmr_pkg::ST_SLEEP] = halted;
					d.rdata[tmr_pkg::ST_ASSIGNED] = ~divider_assign_bit;
				end
				// prescaler has no address; unmapped reads return zero
				default: d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			q.count <= tmr_pkg::COUNT_RESET;
			q.option <= tmr_pkg::OPTION_RESET;
			q.wrap_flag <= 1'b0;
			q.wrap_irq_enable <= 1'b0;
			q.hold <= 2'h0;
			q.rdata <= 8'h00;
			q.sleep_s1 <= 1'b0;
			q.sleep_s2 <= 1'b0;
		end else if (clk_en) begin
			q <= d;
		end
	end

	assign reg_rdata = q.rdata;
	assign wrap_irq = q.wrap_flag & q.wrap_irq_enable;
endmodule // eight_bit_timer

/* testbench/eight_bit_timer_asserts.sv */
// Purpose: port checks of the timer
// Assumes: no strobe while clk_en is low
// Notes: none
`timescale 1ns/10ps
module eight_bit_timer_asserts (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic external_count_pin,
	input wire logic sleep_mode,
	input wire logic wdt_timeout_in,
	input wire logic wdt_tick,
	input wire logic wrap_irq
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	a_rdata_idle: assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00)
		else $error("rdata");
	a_count_hold: assert property (
		clk_en && reg_wr && reg_addr == 4'h0 ##1
		reg_rd && reg_addr == 4'h0 |=> reg_rdata == $past(reg_wdata, 2))
		else $error("hold");
	a_hold_late: assert property (
		clk_en && reg_wr && reg_addr == 4'h0 ##1 !reg_wr
		##1 reg_rd && reg_addr == 4'h0
		|=> reg_rdata == $past(reg_wdata, 3)) else $error("hold2");
	a_unmapped_rd: assert property (
		clk_en && reg_rd && reg_addr > 4'h3 |=> reg_rdata == 8'h00)
		else $error("unmapped");
	a_option_rd: assert property (
		clk_en && reg_wr && reg_addr == 4'h1 ##1 reg_rd && reg_addr == 4'h1
		|=> ((reg_rdata ^ $past(reg_wdata, 2)) & 8'h3F) == 8'h00)
		else $error("option");
	a_irq_mask: assert property (
		clk_en && reg_wr && reg_addr == 4'h2 && !reg_wdata[5] |=> !wrap_irq)
		else $error("mask");
	a_irq_set: assert property (
		clk_en && reg_wr && reg_addr == 4'h2 && reg_wdata[5] && reg_wdata[2]
		|=> wrap_irq) else $error("irq");
	a_sleep_halt: assert property (
		sleep_mode [*5] ##0 reg_wr && reg_addr == 4'h0 ##1 sleep_mode [*3]
		##1 reg_rd && reg_addr == 4'h0
		|=> reg_rdata == $past(reg_wdata, 5)) else $error("sleep");
	a_wdt_gate: assert property (wdt_tick |-> wdt_timeout_in)
		else $error("wdt");
endmodule // eight_bit_timer_asserts
bind eight_bit_timer eight_bit_timer_asserts u_chk (.core_clk, .rst_b,
	.clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.external_count_pin, .sleep_mode, .wdt_timeout_in, .wdt_tick, .wrap_irq);

/* testbench/count_source.sv */
// Purpose: external count source
// Assumes: a level lasts half+1 cycles
// Notes: pin rests where the last toggle left it
`timescale 1ns/10ps
module count_source (
	input wire logic core_clk,
	input wire logic start,
	input wire logic [7:0] toggles,
	input wire logic [2:0] half,
	output logic pin,
	output logic busy
);
	logic [7:0] left_q = 8'h00;
	logic [2:0] tick_q = 3'h0;
	initial pin = 1'b0;
	assign busy = left_q != 8'h00;
	always @(posedge core_clk) begin
		tick_q <= tick_q == 3'h0 ? half : tick_q - 3'h1;
		if (start)
			left_q <= toggles;
		else if (busy && tick_q == 3'h0) begin
			pin <= !pin;
			left_q <= left_q - 8'h01;
		end
	end
endmodule // count_source

/* testbench/test_eight_bit_timer.sv */
// Purpose: self-checking timer bench
// Assumes: clk_en low only in the freeze scenario
// Notes: seed 21
`timescale 1ns/10ps
module test_eight_bit_timer;
	logic core_clk, rst_b = 0, reg_wr = 0, reg_rd = 0, sleep_mode = 0;
	logic wdt_in = 0, start = 0, clk_en = 1, busy, pin, lvl, wdt_tick;
	logic wrap_irq;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, toggles = 8'h00, x, v;
	logic [2:0] half = 3'h1;
	int failures, tests_run, k, n;
	eight_bit_timer u_dut (.core_clk, .rst_b, .clk_en, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .external_count_pin(pin),
		.sleep_mode, .wdt_timeout_in(wdt_in), .wdt_tick, .wrap_irq);
	count_source u_src (.core_clk, .start, .toggles, .half, .pin, .busy);
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = !core_clk;
	end
	always @(posedge core_clk) wdt_in <= 1'($urandom);
	function automatic logic [7:0] held(logic [7:0] a, int c);
		// write edge, two held edges, then one step per edge
		return a + 8'(c > 3 ? c - 3 : 0);
	endfunction
	function automatic logic [7:0] edges(logic l, logic [7:0] t, logic f);
		return f ? t - (l ? t / 2 : (t + 1) / 2) : (l ? t / 2 : (t + 1) / 2);
	endfunction
	task automatic chk(logic [7:0] e, logic [7:0] g, string s);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("FAIL %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [7:0] d);
		// strobe still falling from a previous write: let one edge pass
		if (reg_wr)
			@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [3:0] a);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		v = reg_rdata;
		@(posedge core_clk);
	endtask
	task automatic rc(logic [3:0] a, logic [7:0] e, string s);
		rd(a);
		chk(e, v, s);
	endtask
	task automatic final_report;
		if (failures == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		x = 8'($urandom(21));
		repeat (20) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		rc(4'h1, 8'hFF, "option");
		rc(4'h3, 8'h00, "status");
		for (k = 4; k < 16; k++)
			rc(4'(k), 8'h00, "unmapped");
		wr(4'h1, 8'h08);
		for (k = 1; k < 12; k++) begin
			x = 8'($urandom);
			wr(4'h0, x);
			repeat (k - 1) @(posedge core_clk);
			rc(4'h0, held(x, k), "timer");
		end
		// enable low must freeze the count and the write hold alike
		wr(4'h0, x);
		clk_en <= 1'b0;
		repeat (9) @(posedge core_clk);
		clk_en <= 1'b1;
		rc(4'h0, x, "freeze");
		wr(4'h0, 8'h00);
		wr(4'h2, 8'h00);
		wr(4'h0, 8'hFE);
		rc(4'h3, 8'h01, "inhibit");
		repeat (3) @(posedge core_clk);
		rc(4'h2, 8'h04, "flag");
		wr(4'h2, 8'h24);
		@(negedge core_clk);
		chk(8'h01, 8'(wrap_irq), "irq");
		@(posedge core_clk);
		wr(4'h2, 8'h20);
		rc(4'h2, 8'h20, "clear");
		sleep_mode <= 1'b1;
		repeat (4) @(posedge core_clk);
		wr(4'h0, x);
		repeat (3) @(posedge core_clk);
		rc(4'h0, x, "sleep");
		rc(4'h3, 8'h02, "sleeping");
		sleep_mode <= 1'b0;
		// synchronised sleep level must drain before ratios are timed
		repeat (2) @(posedge core_clk);
		for (k = 0; k < 8; k++) begin
			wr(4'h1, 8'(k));
			rd(4'h0);
			x = v;
			repeat ((2 << k) * 3 - 2) @(posedge core_clk);
			rd(4'h0);
			chk(8'h03, v - x, "ratio");
			@(negedge core_clk);
			chk(8'(wdt_in), 8'(wdt_tick), "wdt_tick");
			@(posedge core_clk);
		end
		rc(4'h3, 8'h04, "assigned");
		wr(4'h0, 8'h00);
		repeat (200) @(posedge core_clk);
		rc(4'h0, 8'h00, "clear");
		for (k = 0; k < 4; k++) begin
			x = 8'h28 | 8'(k % 2 * 16);
			wr(4'h1, x);
			rc(4'h1, x, "option");
			wr(4'h0, 8'h00);
			lvl = pin;
			toggles <= 8'($urandom_range(20, 1));
			half <= 3'($urandom_range(4, 1));
			start <= 1'b1;
			repeat (2) @(posedge core_clk);
			start <= 1'b0;
			for (n = 0; busy && n < 999; n++)
				@(posedge core_clk);
			if (busy) begin
				failures++;
				final_report;
			end
			repeat (6) @(posedge core_clk);
			rc(4'h0, edges(lvl, toggles, k % 2 == 1), "edges");
		end
		final_report;
	end
endmodule // test_eight_bit_timer
